// ==== common/clu_pkg.sv ====
// Constants shared by the configurable logic unit.
package clu_pkg;
	localparam int         LUT_COUNT       = 4;
	localparam int         IDX_W           = 5;
	localparam int         BYTE_SHIFT      = 2;
	localparam logic [4:0] IDX_GLOBAL      = 5'h00;
	localparam logic [4:0] IDX_SEQ0        = 5'h01;
	localparam logic [4:0] IDX_SEQ1        = 5'h02;
	localparam logic [4:0] IDX_SENSE       = 5'h05;
	localparam logic [4:0] IDX_FLAGS       = 5'h07;
	localparam logic [4:0] IDX_LUT_GLOBAL_CONTROL   = 5'h08;
	localparam logic [4:0] IDX_LUT_CTRLB   = 5'h09;
	localparam logic [4:0] IDX_LUT_CTRLC   = 5'h0A;
	localparam logic [4:0] IDX_LUT_TRUTH   = 5'h0B;
	localparam logic [4:0] IDX_LUT_LAST    = 5'h17;
	localparam logic [7:0] REG_RESET       = 8'h00;
	localparam logic [7:0] GC_MASK         = 8'h41;
	localparam logic [7:0] LOW4_MASK       = 8'h0F;
	localparam int         GC_ENABLE_BIT   = 0;
	localparam int         GC_RUN_IN_STANDBY_BIT = 6;
	localparam int         CA_EN_BIT       = 0;
	localparam int         CA_CLK_LSB      = 1;
	localparam int         CA_FILT_LSB     = 4;
	localparam int         CA_PIN_OUTPUT_ENABLE_BIT    = 6;
	localparam int         CA_EDGE_BIT     = 7;
	localparam int         CB_IN0_LSB      = 0;
	localparam int         CB_IN1_LSB      = 4;
	localparam int         CC_IN2_LSB      = 0;
	localparam logic [3:0] SEQ_OFF         = 4'h0;
	localparam logic [3:0] SEQ_DFF         = 4'h1;
	localparam logic [3:0] SEQ_JK          = 4'h2;
	localparam logic [3:0] SEQ_LATCH       = 4'h3;
	localparam logic [3:0] SEQ_RS          = 4'h4;
	localparam logic [1:0] SENSE_OFF       = 2'h0;
	localparam logic [1:0] SENSE_RISE      = 2'h1;
	localparam logic [1:0] SENSE_FALL      = 2'h2;
	localparam logic [1:0] SENSE_BOTH      = 2'h3;
	localparam logic [1:0] COND_NONE       = 2'h0;
	localparam logic [1:0] COND_SYNC       = 2'h1;
	localparam logic [1:0] COND_FILTER     = 2'h2;
	localparam logic [2:0] PERIPHERAL_CLOCK         = 3'h0;
	localparam logic [2:0] CLK_IN2         = 3'h1;
	localparam logic [2:0] CLK_FAST        = 3'h4;
	localparam logic [2:0] CLK_32K         = 3'h5;
	localparam logic [2:0] CLK_1K          = 3'h6;
	localparam logic [3:0] IN_MASK         = 4'h0;
	localparam logic [3:0] IN_FEEDBACK     = 4'h1;
	localparam logic [3:0] IN_LINK         = 4'h2;
	localparam logic [3:0] IN_EVENT_A      = 4'h3;
	localparam logic [3:0] IN_EVENT_B      = 4'h4;
	localparam logic [3:0] IN_PIN          = 4'h5;
	localparam logic [3:0] IN_COMPARATOR   = 4'h6;
	localparam logic [3:0] IN_SERIAL       = 4'h8;
	localparam logic [3:0] IN_SPI          = 4'h9;
	localparam logic [3:0] IN_WAVEFORM     = 4'hA;
	localparam logic [3:0] IN_AUX_TIMER    = 4'hC;
endpackage

// ==== hdl/clu_custom_logic_unit.sv ====
// Four-LUT configurable logic unit with an AHB-Lite register slave.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module clu_custom_logic_unit
	import clu_pkg::*;
#(
	parameter int FILTER_TAPS = 4
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [3:0]  event_channel_a,
	input  wire logic [3:0]  event_channel_b,
	input  wire logic [3:0]  pin_in0,
	input  wire logic [3:0]  pin_in1,
	input  wire logic [3:0]  pin_in2,
	input  wire logic        comparator_output,
	input  wire logic        serial_port_first_tx,
	input  wire logic        serial_port_second_tx,
	input  wire logic        serial_port_third_tx,
	input  wire logic        spi_block_mosi,
	input  wire logic        spi_block_sck,
	input  wire logic [2:0]  waveform_timer_wo,
	input  wire logic        aux_timer_first_wo,
	input  wire logic        aux_timer_second_wo,
	input  wire logic        aux_timer_third_wo,
	input  wire logic        fast_oscillator,
	input  wire logic        low_power_32k_oscillator,
	input  wire logic        low_power_1k_clock,
	input  wire logic        standby_sleep,
	output logic      [3:0]  lut_out,
	output logic      [3:0]  pin_out,
	output logic      [3:0]  pin_oe,
	output logic             peripheral_clock_request
);

	////////////////////////////////////////////////////////////////////////
	logic [7:0]       gctl_reg, gctl_next;
	logic [1:0][7:0]  seq_reg, seq_next;
	logic [7:0]       sense_reg, sense_next;
	logic [3:0]       flags_reg, flags_next;
	logic [3:0][7:0]  ctla_reg, ctla_next;
	logic [3:0][7:0]  ctlb_reg, ctlb_next;
	logic [3:0][7:0]  ctlc_reg, ctlc_next;
	logic [3:0][7:0]  truth_reg, truth_next;
	logic             wr_pend_reg, wr_pend_next;
	logic             rd_pend_reg, rd_pend_next;
	logic [4:0]       idx_reg, idx_next;
	logic [31:0]      hrdata_reg, hrdata_next;
	logic             hready_reg, hready_next;
	logic [3:0]       out_reg, out_next;
	logic [3:0]       prev_reg;
	logic [3:0]       pout_reg, poe_reg, poe_next;
	logic             preq_reg, preq_next;
	logic [3:0]       in2_prev_reg;
	logic [2:0]       osc_prev_reg;
	logic             accept;
	logic             addr_hi_ok;
	logic             gen;
	logic             halt;
	logic [4:0]       rel;
	logic [7:0]       rd_val;
	logic [3:0]       wr_ones;
	logic [3:0]       flag_set;
	logic [3:0]       rise, fall;
	logic [3:0]       active, clk_en, uses_clk;
	logic [3:0]       in0, in1, in2;
	logic [3:0]       comb_out, det_out, fin_out;
	logic [1:0]       seq_q;
	logic [2:0]       osc_rise;

	assign gen      = gctl_reg[GC_ENABLE_BIT];
	assign halt     = standby_sleep & ~gctl_reg[GC_RUN_IN_STANDBY_BIT];
	assign accept   = hsel & htrans[1] & hready;
	assign addr_hi_ok = (haddr[31:IDX_W+BYTE_SHIFT] == '0);
	assign rel      = idx_reg - IDX_LUT_GLOBAL_CONTROL;
	assign wr_ones  = wr_pend_reg && idx_reg == IDX_FLAGS ? hwdata[3:0] : 4'h0;
	assign rise     = out_reg & ~prev_reg;
	assign fall     = ~out_reg & prev_reg;
	assign osc_rise = {fast_oscillator, low_power_32k_oscillator,
		low_power_1k_clock} & ~osc_prev_reg;

	function automatic logic pick(input logic [3:0] code,
		input logic fb, input logic link, input logic ea, input logic eb,
		input logic io, input logic ac, input logic ser, input logic spi,
		input logic wo, input logic aux);
		logic r;
		r = 1'b0;
		case (code)
			IN_FEEDBACK:   r = fb;
			IN_LINK:       r = link;
			IN_EVENT_A:    r = ea;
			IN_EVENT_B:    r = eb;
			IN_PIN:        r = io;
			IN_COMPARATOR: r = ac;
			IN_SERIAL:     r = ser;
			IN_SPI:        r = spi;
			IN_WAVEFORM:   r = wo;
			IN_AUX_TIMER:  r = aux;
			default:       r = 1'b0;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus and register file. Reads take one wait state so that a read
	// right after a write always sees the written value.
	always_comb
	begin
		wr_pend_next = accept & hwrite & addr_hi_ok;
		rd_pend_next = accept & ~hwrite;
		// A high address lands on an unmapped index, so a master that
		// moves haddr during the data phase cannot change the answer.
		idx_next     = !accept ? idx_reg
			: addr_hi_ok ? haddr[IDX_W+BYTE_SHIFT-1:BYTE_SHIFT] : '1;
		hready_next  = ~(accept & ~hwrite);
		gctl_next    = gctl_reg;
		seq_next     = seq_reg;
		sense_next   = sense_reg;
		ctla_next    = ctla_reg;
		ctlb_next    = ctlb_reg;
		ctlc_next    = ctlc_reg;
		truth_next   = truth_reg;
		rd_val       = 8'h00;
		if (rd_pend_reg)
		begin
			case (idx_reg)
				IDX_GLOBAL: rd_val = gctl_reg;
				IDX_SEQ0:   rd_val = seq_reg[0];
				IDX_SEQ1:   rd_val = seq_reg[1];
				IDX_SENSE:  rd_val = sense_reg;
				IDX_FLAGS:  rd_val = {4'h0, flags_reg};
				default:
				begin
					if (idx_reg >= IDX_LUT_GLOBAL_CONTROL && idx_reg <= IDX_LUT_LAST)
					begin
						case (rel[1:0])
							2'h0:    rd_val = ctla_reg[rel[3:2]];
							2'h1:    rd_val = ctlb_reg[rel[3:2]];
							2'h2:    rd_val = ctlc_reg[rel[3:2]];
							default: rd_val = truth_reg[rel[3:2]];
						endcase
					end
				end
			endcase
		end
		hrdata_next = rd_pend_reg ? {24'h000000, rd_val} : hrdata_reg;
		if (wr_pend_reg)
		begin
			case (idx_reg)
				IDX_GLOBAL: gctl_next = hwdata[7:0] & GC_MASK;
				IDX_SENSE:  sense_next = hwdata[7:0];
				IDX_SEQ0, IDX_SEQ1:
				begin
					if (!gen)
						seq_next[idx_reg[1]] = hwdata[7:0] & LOW4_MASK;
				end
				default:
				begin
					if (!gen && idx_reg >= IDX_LUT_GLOBAL_CONTROL
						&& idx_reg <= IDX_LUT_LAST)
					begin
						case (rel[1:0])
							2'h0:    ctla_next[rel[3:2]] = hwdata[7:0];
							2'h1:    ctlb_next[rel[3:2]] = hwdata[7:0];
							2'h2:    ctlc_next[rel[3:2]] = hwdata[7:0] & LOW4_MASK;
							default: truth_next[rel[3:2]] = hwdata[7:0];
						endcase
					end
				end
			endcase
		end
		// A new event beats a clear in the same cycle.
		flags_next = (flags_reg & ~wr_ones) | flag_set;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gctl_reg    <= REG_RESET;
			seq_reg     <= '0;
			sense_reg   <= REG_RESET;
			flags_reg   <= 4'h0;
			ctla_reg    <= '0;
			ctlb_reg    <= '0;
			ctlc_reg    <= '0;
			truth_reg   <= '0;
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			idx_reg     <= 5'h00;
			hrdata_reg  <= 32'h00000000;
			hready_reg  <= 1'b1;
		end
		else
		begin
			gctl_reg    <= gctl_next;
			seq_reg     <= seq_next;
			sense_reg   <= sense_next;
			flags_reg   <= flags_next;
			ctla_reg    <= ctla_next;
			ctlb_reg    <= ctlb_next;
			ctlc_reg    <= ctlc_next;
			truth_reg   <= truth_next;
			wr_pend_reg <= wr_pend_next;
			rd_pend_reg <= rd_pend_next;
			idx_reg     <= idx_next;
			hrdata_reg  <= hrdata_next;
			hready_reg  <= hready_next;
		end
	end

	assign hrdata    = hrdata_reg;
	assign hreadyout = hready_reg;
	assign hresp     = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Per-LUT datapath. Link inputs read the registered outputs, which
	// keeps a ring of linked LUTs free of combinational loops.
	for (genvar g = 0; g < LUT_COUNT; g++)
	begin : g_lut
		logic [FILTER_TAPS-1:0] sh_reg, sh_next;
		logic                   cond_reg, cond_next;
		logic                   eprev_reg, eprev_next;
		logic                   cond_sel;
		logic [1:0]             filt;
		logic [2:0]             src;
		logic                   fb;
		logic                   link;

		assign filt = ctla_reg[g][CA_FILT_LSB+:2];
		assign src  = ctla_reg[g][CA_CLK_LSB+:3];
		assign fb   = seq_q[g/2];
		assign link = out_reg[(g+1)%LUT_COUNT];
		assign active[g] = gen & ctla_reg[g][CA_EN_BIT];
		assign in0[g] = pick(ctlb_reg[g][CB_IN0_LSB+:4], fb, link,
			event_channel_a[g], event_channel_b[g], pin_in0[g],
			comparator_output, serial_port_first_tx, spi_block_mosi,
			waveform_timer_wo[0], aux_timer_first_wo);
		assign in1[g] = pick(ctlb_reg[g][CB_IN1_LSB+:4], fb, link,
			event_channel_a[g], event_channel_b[g], pin_in1[g],
			comparator_output, serial_port_second_tx, spi_block_mosi,
			waveform_timer_wo[1], aux_timer_second_wo);
		assign in2[g] = pick(ctlc_reg[g][CC_IN2_LSB+:4], fb, link,
			event_channel_a[g], event_channel_b[g], pin_in2[g],
			comparator_output, serial_port_third_tx, spi_block_sck,
			waveform_timer_wo[2], aux_timer_third_wo);
		assign comb_out[g] = truth_reg[g][{in2[g], in1[g], in0[g]}];
		assign uses_clk[g] = (filt != COND_NONE)
			| ctla_reg[g][CA_EDGE_BIT] | (seq_reg[g/2][3:0] != SEQ_OFF);
		assign cond_sel = (filt == COND_NONE) ? comb_out[g] : cond_reg;
		assign det_out[g] = ctla_reg[g][CA_EDGE_BIT]
			? cond_sel & ~eprev_reg : cond_sel;

		always_comb
		begin
			case (src)
				PERIPHERAL_CLOCK:  clk_en[g] = ~halt;
				CLK_IN2:  clk_en[g] = in2[g] & ~in2_prev_reg[g];
				CLK_FAST: clk_en[g] = osc_rise[2];
				CLK_32K:  clk_en[g] = osc_rise[1];
				CLK_1K:   clk_en[g] = osc_rise[0];
				default:  clk_en[g] = 1'b0;
			endcase
			sh_next    = sh_reg;
			cond_next  = cond_reg;
			eprev_next = eprev_reg;
			if (!active[g])
			begin
				sh_next    = '0;
				cond_next  = 1'b0;
				eprev_next = 1'b0;
			end
			else if (clk_en[g])
			begin
				sh_next    = {sh_reg[FILTER_TAPS-2:0], comb_out[g]};
				eprev_next = cond_sel;
				case (filt)
					COND_SYNC: cond_next = sh_reg[0];
					COND_FILTER:
					begin
						// The filter only moves once every tap agrees.
						if (&sh_reg)
							cond_next = 1'b1;
						else if (~|sh_reg)
							cond_next = 1'b0;
					end
					default:   cond_next = cond_reg;
				endcase
			end
		end

		always_ff @(posedge hclk or negedge hresetn)
		begin
			if (!hresetn)
			begin
				sh_reg    <= '0;
				cond_reg  <= 1'b0;
				eprev_reg <= 1'b0;
			end
			else
			begin
				sh_reg    <= sh_next;
				cond_reg  <= cond_next;
				eprev_reg <= eprev_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pair sequencers, each stepped by the even LUT's clock.
	for (genvar p = 0; p < LUT_COUNT / 2; p++)
	begin : g_seq
		logic q_reg, q_next;
		logic a, b, step;

		assign a    = det_out[2*p];
		assign b    = det_out[2*p+1];
		assign step = active[2*p] & clk_en[2*p];

		always_comb
		begin
			q_next = q_reg;
			if (!active[2*p])
				q_next = 1'b0;
			else if (step)
			begin
				case (seq_reg[p][3:0])
					SEQ_DFF:   q_next = a;
					SEQ_JK:    q_next = (a & ~q_reg) | (~b & q_reg);
					SEQ_LATCH: q_next = b ? a : q_reg;
					SEQ_RS:    q_next = a | (~b & q_reg);
					default:   q_next = 1'b0;
				endcase
			end
		end

		always_ff @(posedge hclk or negedge hresetn)
		begin
			if (!hresetn)
				q_reg <= 1'b0;
			else
				q_reg <= q_next;
		end

		assign seq_q[p] = q_reg;
		assign fin_out[2*p] = (seq_reg[p][3:0] == SEQ_OFF) ? a : q_reg;
		assign fin_out[2*p+1] = b;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, pins, edge flags and standby clock request.
	always_comb
	begin
		out_next  = active & fin_out & ~({4{halt}} & uses_clk);
		poe_next  = active & {ctla_reg[3][CA_PIN_OUTPUT_ENABLE_BIT],
			ctla_reg[2][CA_PIN_OUTPUT_ENABLE_BIT], ctla_reg[1][CA_PIN_OUTPUT_ENABLE_BIT],
			ctla_reg[0][CA_PIN_OUTPUT_ENABLE_BIT]};
		preq_next = 1'b0;
		for (int i = 0; i < LUT_COUNT; i++)
		begin
			case (sense_reg[2*i+:2])
				SENSE_RISE: flag_set[i] = rise[i];
				SENSE_FALL: flag_set[i] = fall[i];
				SENSE_BOTH: flag_set[i] = rise[i] | fall[i];
				default:    flag_set[i] = 1'b0;
			endcase
			if (active[i] && uses_clk[i]
				&& ctla_reg[i][CA_CLK_LSB+:3] == PERIPHERAL_CLOCK)
				preq_next = gctl_reg[GC_RUN_IN_STANDBY_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			out_reg      <= 4'h0;
			prev_reg     <= 4'h0;
			pout_reg     <= 4'h0;
			poe_reg      <= 4'h0;
			preq_reg     <= 1'b0;
			in2_prev_reg <= 4'h0;
			osc_prev_reg <= 3'h0;
		end
		else
		begin
			out_reg      <= out_next;
			prev_reg     <= out_reg;
			pout_reg     <= out_next;
			poe_reg      <= poe_next;
			preq_reg     <= preq_next;
			in2_prev_reg <= in2;
			osc_prev_reg <= {fast_oscillator, low_power_32k_oscillator,
				low_power_1k_clock};
		end
	end

	assign lut_out   = out_reg;
	assign pin_out   = pout_reg;
	assign pin_oe    = poe_reg;
	assign peripheral_clock_request = preq_reg;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_read_taken;
		accept && !hwrite;
	endsequence
	sequence s_wait_then_data;
		!hreadyout ##1 hreadyout;
	endsequence

	a_global_off_low: assert property (!gen |=> lut_out == 4'h0)
		else $error("Outputs not low while unit disabled.");
	a_lut_off_low: assert property ((lut_out & ~$past(active)) == 4'h0)
		else $error("Disabled LUT drives its output.");
	a_protect_seq: assert property (wr_pend_reg && gen && idx_reg == IDX_SEQ0
		|=> $stable(seq_reg[0]))
		else $error("Protected selector written while enabled.");
	a_flag_on_rise: assert property (sense_reg[1:0] == SENSE_RISE
		&& rise[0] |=> flags_reg[0])
		else $error("Rising edge did not raise flag 0.");
	a_flag_clear_one: assert property (wr_ones[1] && !flag_set[1]
		|=> !flags_reg[1])
		else $error("Writing one did not clear flag 1.");
	a_flag_keep_zero: assert property (wr_pend_reg && idx_reg == IDX_FLAGS
		&& !hwdata[0] && flags_reg[0] |=> flags_reg[0])
		else $error("Writing zero cleared flag 0.");
	a_pin_follows: assert property (active[0]
		&& ctla_reg[0][CA_PIN_OUTPUT_ENABLE_BIT]
		|=> pin_oe[0] && pin_out[0] == lut_out[0])
		else $error("Pin output not driven from LUT output.");
	a_standby_low: assert property (halt && uses_clk[1] |=> !lut_out[1])
		else $error("Clocked LUT output not forced low in standby.");
	a_no_clk_req: assert property (!gctl_reg[GC_RUN_IN_STANDBY_BIT]
		|=> !peripheral_clock_request)
		else $error("Clock requested without run in standby.");
	a_read_wait: assert property (s_read_taken |=> s_wait_then_data)
		else $error("Read did not answer after one wait state.");
	a_dff_capture: assert property (seq_reg[0][3:0] == SEQ_DFF
		&& active[0] && clk_en[0] |=> seq_q[0] == $past(det_out[0]))
		else $error("D flip-flop sequencer did not capture.");
endmodule

// ==== testbench/clu_source_model.sv ====
// Model of the peripherals, event channels and pins that feed the LUTs.
`timescale 1ns/1ps
module clu_source_model
	import clu_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [3:0] hot,
	input  wire logic [2:0] idx,
	output logic      [3:0] event_channel_a,
	output logic      [3:0] event_channel_b,
	output logic      [3:0] pin_in0,
	output logic      [3:0] pin_in1,
	output logic      [3:0] pin_in2,
	output logic            comparator_output,
	output logic            ser_tx,
	output logic            spi_mosi,
	output logic            spi_sck,
	output logic      [2:0] wave_wo,
	output logic            aux_wo,
	output logic      [2:0] osc
);
	logic [2:0] tick_reg;

	// Apart from the pins, set from idx, and osc, only the source named by hot is high, so a wrong mux choice shows.
	assign event_channel_a = {4{hot == IN_EVENT_A}};
	assign event_channel_b = {4{hot == IN_EVENT_B}};
	assign pin_in0 = {4{idx[0]}};
	assign pin_in1 = {4{idx[1]}};
	assign pin_in2 = {4{idx[2]}};
	assign comparator_output = hot == IN_COMPARATOR;
	// The serial ports run asynchronously, so their transmit lines are valid.
	assign ser_tx = hot == IN_SERIAL;
	// The serial peripheral runs as master; code 4'hD marks its clock line.
	assign spi_mosi = hot == IN_SPI;
	assign spi_sck = hot == 4'hD;
	assign wave_wo = {3{hot == IN_WAVEFORM}};
	assign aux_wo = hot == IN_AUX_TIMER;
	assign osc = tick_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tick_reg <= 3'h0;
		else
			tick_reg <= tick_reg + 3'h1;
	end
endmodule

// ==== testbench/clu_custom_logic_unit_bench.sv ====
// Register and LUT path tests of the logic unit over AHB-Lite.
`timescale 1ns/1ps
module clu_custom_logic_unit_bench
	import clu_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        standby_sleep = 1'b0;
	logic [3:0]  hot = 4'h0;
	logic [2:0]  idx = 3'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [3:0]  ea, eb, p0, p1, p2, lut_out, pin_out, pin_oe;
	logic [2:0]  wave, osc;
	logic        cmp, ser, mosi, sck, aux, pclk_req;
	logic [31:0] rd_val;
	int          n_mismatch = 0;
	int          checks_done = 0;
	localparam logic [7:0] TT0 = 8'h96;
	logic [3:0] codes [8] = '{IN_EVENT_A, IN_EVENT_B, IN_PIN, IN_COMPARATOR,
		IN_SERIAL, IN_SPI, IN_WAVEFORM, IN_AUX_TIMER};
	logic [4:0] rst_idx [9] = '{IDX_GLOBAL, IDX_SEQ0, IDX_SEQ1, IDX_SENSE,
		IDX_FLAGS, IDX_LUT_GLOBAL_CONTROL, IDX_LUT_CTRLB, IDX_LUT_CTRLC, IDX_LUT_TRUTH};

	always #12.5 hclk = ~hclk;

	clu_custom_logic_unit u_clu_custom_logic_unit (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .event_channel_a(ea), .event_channel_b(eb),
		.pin_in0(p0), .pin_in1(p1), .pin_in2(p2), .comparator_output(cmp),
		.serial_port_first_tx(ser), .serial_port_second_tx(ser),
		.serial_port_third_tx(ser), .spi_block_mosi(mosi),
		.spi_block_sck(sck), .waveform_timer_wo(wave),
		.aux_timer_first_wo(aux), .aux_timer_second_wo(aux),
		.aux_timer_third_wo(aux), .fast_oscillator(osc[0]),
		.low_power_32k_oscillator(osc[1]), .low_power_1k_clock(osc[2]),
		.standby_sleep(standby_sleep), .lut_out(lut_out),
		.pin_out(pin_out), .pin_oe(pin_oe),
		.peripheral_clock_request(pclk_req));

	clu_source_model u_clu_source_model (
		.hclk(hclk), .hresetn(hresetn), .hot(hot), .idx(idx),
		.event_channel_a(ea), .event_channel_b(eb), .pin_in0(p0),
		.pin_in1(p1), .pin_in2(p2), .comparator_output(cmp), .ser_tx(ser),
		.spi_mosi(mosi), .spi_sck(sck), .wave_wo(wave), .aux_wo(aux),
		.osc(osc));

	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk_reg(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic chk_pin(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask

	// Sampling at the falling edge sees what the next rising edge takes.
	task automatic wait_rdy(output logic [31:0] d);
		int n;
		n = 0;
		@(negedge hclk);
		while (hreadyout !== 1'b1 && n < 20)
		begin
			n++;
			@(negedge hclk);
		end
		if (hreadyout !== 1'b1)
		begin
			n_mismatch++;
			tally_and_finish();
		end
		d = hrdata;
		@(posedge hclk);
	endtask

	task automatic bus(input logic w, input logic [4:0] i,
		input logic [7:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {25'h0, i, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy(r);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy(r);
	endtask

	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		bus(1'b1, i, d, rd_val);
	endtask

	task automatic rdc(input logic [4:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00, rd_val);
		chk_reg($sformatf("reg %h", i), {24'h0, e}, rd_val);
		chk_pin("hresp", 1'b0, hresp);
	endtask

	task automatic drive(input logic [3:0] h, input logic [2:0] v);
		@(posedge hclk);
		hot <= h;
		idx <= v;
		repeat (3) @(posedge hclk);
		@(negedge hclk);
	endtask

	// Reconfigures pair 0 with the unit off, then restarts from input 0.
	task automatic cfg(input logic [7:0] s, input logic [7:0] a0,
		input logic [7:0] a1);
		wr(IDX_GLOBAL, 8'h00);
		wr(IDX_SEQ0, s);
		wr(IDX_LUT_GLOBAL_CONTROL, a0);
		wr(5'h0C, a1);
		drive(4'h0, 3'h0);
		wr(IDX_GLOBAL, 8'h01);
		wr(IDX_FLAGS, 8'h0F);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rst_idx[k])
			rdc(rst_idx[k], REG_RESET);
		wr(5'h03, 8'hFF);
		rdc(5'h03, 8'h00);
		rdc(5'h18, 8'h00);
		wr(IDX_GLOBAL, 8'hFF);
		rdc(IDX_GLOBAL, GC_MASK);
		wr(IDX_GLOBAL, 8'h00);
		wr(IDX_LUT_TRUTH, TT0);
		wr(IDX_LUT_CTRLB, 8'h55);
		wr(IDX_LUT_CTRLC, 8'h05);
		wr(IDX_LUT_GLOBAL_CONTROL, 8'h41);
		wr(5'h17, 8'hAA);
		wr(5'h15, 8'h02);
		wr(5'h14, 8'h01);
		wr(5'h10, 8'h81);
		rdc(IDX_LUT_GLOBAL_CONTROL, 8'h41);
		wr(IDX_GLOBAL, 8'h01);
		wr(IDX_LUT_TRUTH, 8'h00);
		rdc(IDX_LUT_TRUTH, TT0);
		drive(4'h0, 3'h0);
		chk_pin("clock request", 1'b0, pclk_req);
		wr(IDX_GLOBAL, 8'h41);
		drive(4'h0, 3'h0);
		chk_pin("clock request", 1'b1, pclk_req);
		wr(IDX_GLOBAL, 8'h01);
		for (int v = 0; v < 8; v++)
		begin
			drive(4'h0, 3'(v));
			chk_pin("lut0", TT0[v], lut_out[0]);
			chk_pin("pin0", TT0[v], pin_out[0]);
			chk_pin("oe0", 1'b1, pin_oe[0]);
			chk_pin("lut3", TT0[v], lut_out[3]);
		end
		for (int m = 0; m < 4; m++)
		begin
			drive(4'h0, 3'h0);
			wr(IDX_SENSE, 8'(m));
			wr(IDX_FLAGS, 8'h0F);
			drive(4'h0, 3'h1);
			rdc(IDX_FLAGS, {7'h0, m[0]});
			wr(IDX_FLAGS, 8'h00);
			rdc(IDX_FLAGS, {7'h0, m[0]});
			wr(IDX_FLAGS, 8'h0F);
			drive(4'h0, 3'h0);
			rdc(IDX_FLAGS, {7'h0, m[1]});
			wr(IDX_FLAGS, 8'h01);
			rdc(IDX_FLAGS, 8'h00);
		end
		drive(4'h0, 3'h1);
		wr(IDX_GLOBAL, 8'h00);
		drive(4'h0, 3'h1);
		chk_pin("lut0 off", 1'b0, lut_out[0]);
		wr(5'h0F, 8'hAA);
		wr(5'h0C, 8'h01);
		foreach (codes[c])
		begin
			wr(IDX_GLOBAL, 8'h00);
			wr(5'h0D, {4'h0, codes[c]});
			wr(IDX_GLOBAL, 8'h01);
			foreach (codes[h])
			begin
				drive(codes[h], (codes[h] == IN_PIN) ? 3'h7 : 3'h0);
				chk_pin("lut1", codes[h] == codes[c], lut_out[1]);
			end
		end
		wr(IDX_GLOBAL, 8'h00);
		wr(5'h0F, 8'hF0);
		wr(5'h0E, {4'h0, IN_SPI});
		wr(IDX_GLOBAL, 8'h01);
		drive(IN_SPI, 3'h0);
		chk_pin("lut1 in2", 1'b0, lut_out[1]);
		drive(4'hD, 3'h0);
		chk_pin("lut1 in2", 1'b1, lut_out[1]);
		// LUT 1 now follows the clock line, which acts as reset or gate.
		cfg(8'h00, 8'h40, 8'h01);
		drive(4'h0, 3'h1);
		chk_pin("lut0 en off", 1'b0, lut_out[0]);
		chk_pin("oe0 off", 1'b0, pin_oe[0]);
		cfg({4'h0, SEQ_RS}, 8'h01, 8'h01);
		drive(4'h0, 3'h1);
		chk_pin("rs set", 1'b1, lut_out[0]);
		drive(4'h0, 3'h0);
		chk_pin("rs hold", 1'b1, lut_out[0]);
		drive(4'hD, 3'h0);
		chk_pin("rs reset", 1'b0, lut_out[0]);
		cfg({4'h0, SEQ_OFF}, 8'h81, 8'h01);
		drive(4'h0, 3'h1);
		chk_pin("edge pulse", 1'b0, lut_out[0]);
		rdc(IDX_FLAGS, 8'h01);
		cfg({4'h0, SEQ_OFF}, 8'h1D, 8'h01);
		drive(4'h0, 3'h1);
		chk_pin("sync slow", 1'b0, lut_out[0]);
		repeat (5) drive(4'h0, 3'h1);
		chk_pin("sync late", 1'b1, lut_out[0]);
		cfg({4'h0, SEQ_OFF}, 8'h21, 8'h01);
		drive(4'h0, 3'h1);
		chk_pin("filter early", 1'b0, lut_out[0]);
		drive(4'h0, 3'h1);
		chk_pin("filter late", 1'b1, lut_out[0]);
		// The odd LUT runs on the slow clock, so a prompt capture shows
		// that the even LUT's clock steps the pair.
		cfg({4'h0, SEQ_DFF}, 8'h01, 8'h0D);
		drive(4'h0, 3'h1);
		chk_pin("dff", 1'b1, lut_out[0]);
		@(posedge hclk);
		standby_sleep <= 1'b1;
		drive(4'h0, 3'h1);
		chk_pin("standby", 1'b0, lut_out[0]);
		wr(IDX_GLOBAL, 8'h41);
		drive(4'h0, 3'h1);
		chk_pin("run in standby", 1'b1, lut_out[0]);
		chk_pin("clock request", 1'b1, pclk_req);
		tally_and_finish();
	end
endmodule
